/* File: amc_pkg.sv */
package amc_pkg;

  // startup interval after sleep release; real part depends on reference capacitor
  localparam int unsigned CLK_HZ         = 50_000_000;
  localparam int unsigned STARTUP_US     = 130_000;
  localparam int unsigned STARTUP_CYCLES = STARTUP_US * (CLK_HZ / 1_000_000);
  // spurious warning glitch width allowed at power-up or sleep release
  localparam int unsigned GLITCH_NS      = 1_000;
  localparam int unsigned GLITCH_CYCLES  = GLITCH_NS / 20;
  localparam int unsigned SYNC_STAGES    = 2;

  typedef enum logic [1:0] {
    AMC_SLEEP,
    AMC_STARTUP,
    AMC_RUN
  } amc_state_t;

endpackage : amc_pkg

/* File: amc_sync.sv */
`timescale 1ns/100ps
module amc_sync
  import amc_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : amc_sync

/* File: amc_ctrl.sv */
// Function
// - mute high forces all four bridge outputs low, muted state
// - mute low in normal operation passes the modulated pulse stream to all four outputs
// - overcurrent detection is disabled while muted
// - sleep high shuts down, holds outputs muted, minimum power
// - during sleep both detectors are off and warning is low
// - after sleep release, normal operation only after the startup interval
// - warning high when either overcurrent or overtemperature is reported
// - overcurrent warning stays latched after current returns to normal
// - latched overcurrent clears only by sleep low-high-low or power-up
// - warning raised when junction temperature exceeds its maximum
// - overtemperature warning clears by itself once cooled
// - overtemperature warning also cleared by sleep high or power-up
// - a short warning glitch may appear at power-up or sleep release
// - mute and sleep act on both channels at once
`timescale 1ns/100ps
module amc_ctrl
  import amc_pkg::*;
#(
  parameter int unsigned STARTUP_CNT = STARTUP_CYCLES
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic mute_in,
  input  wire logic sleep_in,
  input  wire logic overcurrent_in,
  input  wire logic overtemp_in,
  input  wire logic pulse_left_pos,
  input  wire logic pulse_left_neg,
  input  wire logic pulse_right_pos,
  input  wire logic pulse_right_neg,
  output logic      left_pos_out,
  output logic      left_neg_out,
  output logic      right_pos_out,
  output logic      right_neg_out,
  output logic      fault_warning_out,
  output logic      running_out,
  output logic      powered_down_out
);

  localparam int CW = $clog2(STARTUP_CNT + 1);

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisation
  logic [3:0] sync_q;
  logic       mute_s;
  logic       sleep_s;
  logic       oc_s;
  logic       ot_s;

  amc_sync #(.WIDTH(4)) u_sync (
    .clock    (clock),
    .arst_n   (arst_n),
    .async_in ({mute_in, sleep_in, overcurrent_in, overtemp_in}),
    .sync_out (sync_q)
  );

  assign mute_s  = sync_q[3];
  assign sleep_s = sync_q[2];
  assign oc_s    = sync_q[1];
  assign ot_s    = sync_q[0];

  //////////////////////////////////////////////////////////////////////////////
  // power state sequencing
  amc_state_t     state_reg;
  logic [CW-1:0]  start_cnt_reg;
  logic           sleep_seen_reg;
  logic           running;

  assign running = (state_reg == AMC_RUN);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg     <= AMC_STARTUP; // power-up counts as a sleep release
      start_cnt_reg <= '0;
    end else begin
      case (state_reg)
        AMC_SLEEP: begin
          start_cnt_reg <= '0;
          if (!sleep_s) begin
            state_reg <= AMC_STARTUP;
          end
        end
        AMC_STARTUP: begin
          if (sleep_s) begin
            state_reg <= AMC_SLEEP;
          end else if (start_cnt_reg == CW'(STARTUP_CNT - 1)) begin
            state_reg <= AMC_RUN;
          end else begin
            start_cnt_reg <= start_cnt_reg + 1'b1;
          end
        end
        AMC_RUN: begin
          start_cnt_reg <= '0;
          if (sleep_s) begin
            state_reg <= AMC_SLEEP;
          end
        end
        default: begin
          state_reg <= AMC_SLEEP;
        end
      endcase
    end
  end

  // remembers that sleep went high since the last low, to catch low-high-low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sleep_seen_reg <= 1'b0;
    end else if (sleep_s) begin
      sleep_seen_reg <= 1'b1;
    end else begin
      sleep_seen_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fault detection and warning
  logic oc_latch_reg;
  logic oc_live;
  logic ot_live;
  logic muted;

  // a sleep request or the sleep state both switch the detectors and warning off
  function automatic logic amc_asleep(input amc_state_t st, input logic req);
    return req || (st == AMC_SLEEP);
  endfunction : amc_asleep

  // one mute for both channels; sleep and startup also keep outputs muted
  assign muted   = mute_s || !running;
  assign oc_live = oc_s && running && !mute_s && !sleep_s;
  assign ot_live = ot_s && !amc_asleep(state_reg, sleep_s);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      oc_latch_reg <= 1'b0;
    end else if (oc_live) begin
      oc_latch_reg <= 1'b1;
    end else if (sleep_seen_reg && !sleep_s) begin
      // sleep falling completes low-high-low; the set above wins if coincident
      oc_latch_reg <= 1'b0;
    end
  end

  // no glitch is made at power-up or sleep release; hosts must filter one anyway,
  // so its absence is allowed rather than promised
  // overtemperature is not latched: it follows the detector and so self-clears
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fault_warning_out <= 1'b0;
    end else if (amc_asleep(state_reg, sleep_s)) begin
      fault_warning_out <= 1'b0;
    end else begin
      fault_warning_out <= oc_latch_reg || oc_live || ot_live;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bridge outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      left_pos_out  <= 1'b0;
      left_neg_out  <= 1'b0;
      right_pos_out <= 1'b0;
      right_neg_out <= 1'b0;
    end else if (muted) begin
      left_pos_out  <= 1'b0;
      left_neg_out  <= 1'b0;
      right_pos_out <= 1'b0;
      right_neg_out <= 1'b0;
    end else begin
      left_pos_out  <= pulse_left_pos;
      left_neg_out  <= pulse_left_neg;
      right_pos_out <= pulse_right_pos;
      right_neg_out <= pulse_right_neg;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      running_out      <= 1'b0;
      powered_down_out <= 1'b0;
    end else begin
      running_out      <= running;
      powered_down_out <= (state_reg == AMC_SLEEP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  a_mute_forces_low: assert property (
    @(posedge clock) disable iff (!arst_n)
    mute_s |=> !left_pos_out && !left_neg_out && !right_pos_out && !right_neg_out)
    else $error("outputs not low while muted");

  a_run_passes_pulse: assert property (
    @(posedge clock) disable iff (!arst_n)
    (running && !mute_s) |=> (left_pos_out == $past(pulse_left_pos)) && (right_neg_out == $past(pulse_right_neg)))
    else $error("pulse stream not passed when unmuted");

  a_mute_no_oc: assert property (
    @(posedge clock) disable iff (!arst_n)
    (mute_s && !oc_latch_reg) |=> !oc_latch_reg)
    else $error("overcurrent latched while muted");

  a_sleep_warn_low: assert property (
    @(posedge clock) disable iff (!arst_n)
    sleep_s |=> !fault_warning_out && !running)
    else $error("warning or run during sleep");

  a_startup_wait: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_reg == AMC_STARTUP && start_cnt_reg == '0 && !sleep_s) |=> !running)
    else $error("run entered before startup interval");

  a_warn_on_fault: assert property (
    @(posedge clock) disable iff (!arst_n)
    (ot_live || oc_live) |=> fault_warning_out)
    else $error("warning missing on fault");

  a_oc_holds: assert property (
    @(posedge clock) disable iff (!arst_n)
    (oc_latch_reg && !sleep_s && !sleep_seen_reg) |=> oc_latch_reg)
    else $error("overcurrent latch dropped early");

  a_oc_clear_seq: assert property (
    @(posedge clock) disable iff (!arst_n)
    (sleep_seen_reg && !sleep_s && !oc_live) |=> !oc_latch_reg)
    else $error("overcurrent latch not cleared by sleep toggle");

  a_pulse_other_legs: assert property (
    @(posedge clock) disable iff (!arst_n)
    (running && !mute_s) |=> (left_neg_out == $past(pulse_left_neg)) && (right_pos_out == $past(pulse_right_pos)))
    else $error("pulse stream not passed on inner legs");

  a_oc_refused_idle: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!running && !oc_latch_reg) |=> !oc_latch_reg)
    else $error("overcurrent latched outside normal operation");

  a_sleep_outs_low: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_reg == AMC_SLEEP) |=> !left_pos_out && !left_neg_out && !right_pos_out && !right_neg_out)
    else $error("outputs not low in sleep");

  a_down_flag: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_reg == AMC_SLEEP) |=> powered_down_out)
    else $error("powered down flag missing in sleep");

  a_sleep_blocks_oc: assert property (
    @(posedge clock) disable iff (!arst_n)
    (sleep_s && !oc_latch_reg) |=> !oc_latch_reg)
    else $error("overcurrent latched during sleep request");

  a_startup_length: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(running) |-> ($past(state_reg) == AMC_STARTUP) && ($past(start_cnt_reg) == CW'(STARTUP_CNT - 1)))
    else $error("run entered without full startup interval");

  a_run_flag: assert property (
    @(posedge clock) disable iff (!arst_n)
    running |=> running_out)
    else $error("running flag missing in normal operation");

  a_warn_from_latch: assert property (
    @(posedge clock) disable iff (!arst_n)
    (oc_latch_reg && !amc_asleep(state_reg, sleep_s)) |=> fault_warning_out)
    else $error("latched overcurrent not shown on warning");

  a_oc_sets_latch: assert property (
    @(posedge clock) disable iff (!arst_n)
    oc_live |=> oc_latch_reg)
    else $error("overcurrent not latched");

  a_ot_raises_warn: assert property (
    @(posedge clock) disable iff (!arst_n)
    (ot_s && !amc_asleep(state_reg, sleep_s)) |=> fault_warning_out)
    else $error("overtemperature not shown on warning");

  a_ot_self_clear: assert property (
    @(posedge clock) disable iff (!arst_n)
    (!ot_s && !oc_latch_reg && !oc_live) |=> !fault_warning_out)
    else $error("warning stays without any fault");

  a_asleep_no_warn: assert property (
    @(posedge clock) disable iff (!arst_n)
    (state_reg == AMC_SLEEP) |-> !fault_warning_out)
    else $error("warning high in sleep state");

  a_both_chan_mute: assert property (
    @(posedge clock) disable iff (!arst_n)
    muted |=> !(left_pos_out || left_neg_out || right_pos_out || right_neg_out))
    else $error("a channel still driven while muted");

  a_sync_mute_lag: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(mute_s) |-> $past(mute_in, 2))
    else $error("mute used without two stage synchroniser");

  a_sync_sleep_lag: assert property (
    @(posedge clock) disable iff (!arst_n)
    $rose(sleep_s) |-> $past(sleep_in, 2))
    else $error("sleep used without two stage synchroniser");

endmodule : amc_ctrl

/* File: amc_host.sv */
`timescale 1ns/100ps
module amc_host
  import amc_pkg::*;
#(
  parameter int FILT = 500,
  parameter int HOLD = 1000
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic enable,
  input  wire logic warn_in,
  output logic      sleep_out
);
  int filt_reg;
  int hold_reg;

  // rise-delay stage: glitches shorter than the filter never reach sleep
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      filt_reg  <= 0;
      hold_reg  <= 0;
      sleep_out <= 1'h0;
    end else if (hold_reg != 0) begin
      hold_reg  <= hold_reg - 1;
      sleep_out <= hold_reg != 1;
    end else if (enable && warn_in) begin
      filt_reg <= filt_reg + 1;
      if (filt_reg >= FILT) begin
        sleep_out <= 1'h1;
        hold_reg  <= HOLD;
        filt_reg  <= 0;
      end
    end else begin
      filt_reg <= 0;
    end
  end
endmodule : amc_host

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench
  import amc_pkg::*;
;
  logic       clock    = 1'h0;
  logic       arst_n   = 1'h0;
  logic       mute_in  = 1'h0;
  logic       sleep_tb = 1'h0;
  logic       oc       = 1'h0;
  logic       ot       = 1'h0;
  logic       host_en  = 1'h0;
  logic [3:0] pulse    = 4'h0;
  logic [3:0] outs;
  logic       warn;
  logic       run;
  logic       down;
  logic       host_sleep;
  int         n_mismatch = 0;
  int         samples_checked = 0;
  // mute, pulses, expected bridge outputs
  logic [8:0] rows [4] = '{9'h0AA, 9'h055, 9'h1F0, 9'h0FF};

  always #10 clock = ~clock;

  amc_ctrl #(.STARTUP_CNT(20)) i_dut (.clock(clock), .arst_n(arst_n), .mute_in(mute_in),
    .sleep_in(sleep_tb | host_sleep), .overcurrent_in(oc), .overtemp_in(ot),
    .pulse_left_pos(pulse[3]), .pulse_left_neg(pulse[2]), .pulse_right_pos(pulse[1]),
    .pulse_right_neg(pulse[0]), .left_pos_out(outs[3]), .left_neg_out(outs[2]),
    .right_pos_out(outs[1]), .right_neg_out(outs[0]), .fault_warning_out(warn),
    .running_out(run), .powered_down_out(down));

  amc_host #(.FILT(500), .HOLD(50)) i_host (.clock(clock), .arst_n(arst_n),
    .enable(host_en), .warn_in(warn), .sleep_out(host_sleep));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string name);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task automatic wait_run();
    for (int i = 0; i < 200 && run !== 1'h1; i++) step(1);
  endtask : wait_run

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    arst_n <= 1'h1;
    step(4);
    chk({run, outs[3], outs[0], warn}, 4'h0, "startup");
    wait_run();
    chk({3'h0, run}, 4'h1, "run");
    foreach (rows[i]) begin
      @(posedge clock);
      mute_in <= rows[i][8];
      pulse   <= rows[i][7:4];
      step(4);
      chk(outs, rows[i][3:0], "outs");
    end
    @(posedge clock);
    ot <= 1'h1;
    step(4);
    chk({3'h0, warn}, 4'h1, "ot warn");
    @(posedge clock);
    ot <= 1'h0;
    step(4);
    chk({3'h0, warn}, 4'h0, "ot gone");
    @(posedge clock);
    mute_in <= 1'h1;
    oc      <= 1'h1;
    step(5);
    chk({3'h0, warn}, 4'h0, "oc muted");
    @(posedge clock);
    mute_in <= 1'h0;
    step(5);
    chk({3'h0, warn}, 4'h1, "oc warn");
    // overtemperature stays low here so that only the latch can hold the warning
    @(posedge clock);
    oc <= 1'h0;
    step(10);
    chk({3'h0, warn}, 4'h1, "oc held");
    @(posedge clock);
    sleep_tb <= 1'h1;
    ot       <= 1'h1;
    step(5);
    chk({down, warn, outs[3] | outs[2], outs[1] | outs[0]}, 4'h8, "sleep");
    @(posedge clock);
    sleep_tb <= 1'h0;
    ot       <= 1'h0;
    step(5);
    chk({2'h0, run, warn}, 4'h0, "restart");
    wait_run();
    chk({run, warn, 2'h0}, 4'h8, "cleared");
    @(posedge clock);
    host_en <= 1'h1;
    oc      <= 1'h1;
    step(400);
    chk({2'h0, down, warn}, 4'h1, "host filter");
    for (int i = 0; i < 1000 && down !== 1'h1; i++) step(1);
    chk({3'h0, down}, 4'h1, "host sleep");
    @(posedge clock);
    oc <= 1'h0;
    step(60);
    wait_run();
    chk({run, warn, 2'h0}, 4'h8, "recover");
    @(posedge clock);
    host_en <= 1'h0;
    oc      <= 1'h1;
    step(5);
    chk({3'h0, warn}, 4'h1, "oc again");
    @(posedge clock);
    oc     <= 1'h0;
    arst_n <= 1'h0;
    step(1);
    chk({run, down, warn, outs[3]}, 4'h0, "in reset");
    step(1);
    @(posedge clock);
    arst_n <= 1'h1;
    step(4);
    chk({2'h0, run, warn}, 4'h0, "reset startup");
    wait_run();
    chk({run, warn, 2'h0}, 4'h8, "power-up clear");
    give_verdict();
  end

  // the whole sequence needs about 720 cycles
  initial begin
    #100_000;
    n_mismatch++;
    give_verdict();
  end
endmodule : testbench
